// ==== tfm_regs.svh ====
// Purpose: register offsets, field positions and reset values of the threshold flag block
// Assumes: 10-bit register address, 8-bit registers
// Notes:   definitions only
`ifndef TFM_REGS_SVH
`define TFM_REGS_SVH
// register offsets
`define TFM_OFS_FLAG_CTL     10'h245
`define TFM_OFS_UPPER_LO     10'h247
`define TFM_OFS_UPPER_HI     10'h248
`define TFM_OFS_LOWER_LO     10'h249
`define TFM_OFS_LOWER_HI     10'h24A
`define TFM_OFS_DWELL_LO     10'h24B
`define TFM_OFS_DWELL_HI     10'h24C
`define TFM_OFS_SYNC_CTL     10'h26F
`define TFM_OFS_PERIOD0      10'h271
`define TFM_OFS_PERIOD1      10'h272
`define TFM_OFS_PERIOD2      10'h273
`define TFM_OFS_IRQ_STATUS   10'h280
`define TFM_OFS_IRQ_MASK     10'h281
`define TFM_OFS_LIVE_STATE   10'h282
// flag control fields
`define TFM_FLAG_EN          0
`define TFM_FLAG_FVAL        2
`define TFM_FLAG_FORCE       3
// monitor sync control fields
`define TFM_SYNC_EN          0
`define TFM_SYNC_NEXT        1
// interrupt status / mask fields
`define TFM_IRQ_RISE         0
`define TFM_IRQ_FALL         1
`define TFM_IRQ_SYNC         2
// reset values
`define TFM_RST_BYTE         8'h00
`define TFM_RST_PERIOD0      8'h80
`define TFM_RST_PERIOD_HI    8'h00
// high threshold bytes keep five bits
`define TFM_HI_MASK          8'h1F
`endif

// ==== tfm_pkg.sv ====
// Purpose: shared types of the threshold flag block
// Assumes: nothing beyond SystemVerilog
// Notes:   constants live in tfm_regs.svh
package tfm_pkg;
  // flag tracking state, one-hot
  typedef enum logic [1:0] {
    TFM_FLAG_LOW  = 2'b01,
    TFM_FLAG_HIGH = 2'b10
  } tfm_flag_state_t;
  typedef logic [12:0] tfm_thresh_t;  // threshold and magnitude
  typedef logic [15:0] tfm_dwell_t;   // dwell counter
  typedef logic [23:0] tfm_period_t;  // monitor period counter
endpackage

// ==== tfm_top.sv ====
// Purpose: threshold flag pin control and signal-monitor period sync for one channel
// Assumes: 40 MHz mclk_i; fine_mag_i on the same clock; sysref_i asynchronous
// Notes:   registers at their printed offsets over a plain strobe port
// Operation
// - flag driven by comparison only when enabled
// - force bit overrides comparison result
// - forced pin takes the force value bit
// - upper threshold thirteen bits over two registers
// - lower threshold thirteen bits over two registers
// - dwell count below lower clears flag
// - sync enable aligns monitor to sysref
// - next mode uses only first sysref edge
// - next mode clears sync enable after use
// - monitor runs over 24-bit even period
`timescale 1ns/1ps
`default_nettype none
`include "tfm_regs.svh"
module tfm_top
  import tfm_pkg::*;
(
  input  wire logic        mclk_i,        // 40 MHz
  input  wire logic        rst_n_i,       // async, active low
  input  wire logic        ce_i,          // freezes all state while low
  input  wire logic [9:0]  addr_i,        // register offset
  input  wire logic [7:0]  wdata_i,       // write data
  input  wire logic        wr_i,          // write strobe
  input  wire logic        rd_i,          // read strobe
  output logic      [7:0]  rdata_o,       // read data, cycle after rd_i
  input  wire logic [12:0] fine_mag_i,    // fine adc magnitude
  input  wire logic        sysref_i,      // timing reference pin
  output logic             threshold_flag_pin_o,
  output logic             period_tick_o, // monitor period boundary
  output logic             irq_o          // level interrupt
);

  // register file
  logic [7:0]  flag_ctl, upper_lo, upper_hi, lower_lo, lower_hi;
  logic [7:0]  dwell_lo, dwell_hi, sync_ctl, period0, period1, period2;
  logic [2:0]  irq_status, irq_mask;
  logic [7:0]  next_flag_ctl, next_upper_lo, next_upper_hi, next_lower_lo, next_lower_hi;
  logic [7:0]  next_dwell_lo, next_dwell_hi, next_sync_ctl, next_period0, next_period1, next_period2;
  logic [2:0]  next_irq_status, next_irq_mask;
  logic [7:0]  next_rdata;
  logic        next_irq;
  // flag datapath
  tfm_flag_state_t flag_st, next_flag_st;
  tfm_dwell_t      dwell_cnt, next_dwell_cnt;
  logic            next_pin;
  // sync and period
  logic            sref_meta, sref_sync, sref_prev;
  tfm_period_t     pcnt, next_pcnt;
  logic            next_tick;

  // decoded views
  tfm_thresh_t upper_thr;
  tfm_thresh_t lower_thr;
  tfm_dwell_t  dwell_target;
  tfm_period_t period_val;
  logic        above_upper, below_lower, sref_edge, sync_hit;

  assign upper_thr    = {upper_hi[4:0], upper_lo};
  assign lower_thr    = {lower_hi[4:0], lower_lo};
  assign dwell_target = {dwell_hi, dwell_lo};
  assign period_val   = {period2, period1, period0};
  assign above_upper  = fine_mag_i > upper_thr;
  assign below_lower  = fine_mag_i < lower_thr;
  // first sync flop is read only by the second one
  assign sref_edge    = sref_sync & ~sref_prev;
  // an edge only counts while sync is enabled; disabled means ignored
  assign sync_hit     = sref_edge & sync_ctl[`TFM_SYNC_EN];

  // flag next state: enable gates tracking; force decides the pin over enable and compare
  always_comb begin
    next_flag_st   = flag_st;
    next_dwell_cnt = dwell_cnt;
    next_pin       = 1'b0;
    if (!flag_ctl[`TFM_FLAG_EN]) begin
      // disabled: tracking parked, dwell counter kept loaded
      next_flag_st   = TFM_FLAG_LOW;
      next_dwell_cnt = dwell_target;
    end else begin
      unique case (flag_st)
        TFM_FLAG_LOW: begin
          next_dwell_cnt = dwell_target;
          if (above_upper) begin
            next_flag_st = TFM_FLAG_HIGH;
          end
        end
        TFM_FLAG_HIGH: begin
          if (above_upper || !below_lower) begin
            // any sample not below lower restarts the dwell
            next_dwell_cnt = dwell_target;
          end else if (dwell_cnt == 16'h0000) begin
            next_flag_st   = TFM_FLAG_LOW;
            next_dwell_cnt = dwell_target;
          end else begin
            next_dwell_cnt = dwell_cnt - 16'h0001;
          end
        end
        default: begin
          next_flag_st   = TFM_FLAG_LOW;
          next_dwell_cnt = dwell_target;
        end
      endcase
    end
    if (flag_ctl[`TFM_FLAG_FORCE]) begin
      next_pin = flag_ctl[`TFM_FLAG_FVAL];
    end else begin
      next_pin = flag_ctl[`TFM_FLAG_EN] && (next_flag_st == TFM_FLAG_HIGH);
    end
  end

  // flag registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_st              <= TFM_FLAG_LOW;
      dwell_cnt            <= 16'h0000;
      threshold_flag_pin_o <= 1'b0;
    end else if (ce_i) begin
      flag_st              <= next_flag_st;
      dwell_cnt            <= next_dwell_cnt;
      threshold_flag_pin_o <= next_pin;
    end
  end

  // sysref synchroniser and edge history
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sref_meta <= 1'b0;
      sref_sync <= 1'b0;
      sref_prev <= 1'b0;
    end else if (ce_i) begin
      sref_meta <= sysref_i;
      sref_sync <= sref_meta;
      sref_prev <= sref_sync;
    end
  end

  // monitor period counter; odd or zero periods are unsupported and
  // simply wrap at whatever period_val - 1 gives
  always_comb begin
    next_tick = 1'b0;
    if (sync_hit) begin
      next_pcnt = 24'h000000;
    end else if (pcnt >= period_val - 24'h000001) begin
      next_pcnt = 24'h000000;
      next_tick = 1'b1;
    end else begin
      next_pcnt = pcnt + 24'h000001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pcnt          <= 24'h000000;
      period_tick_o <= 1'b0;
    end else if (ce_i) begin
      pcnt          <= next_pcnt;
      period_tick_o <= next_tick;
    end
  end

  // register writes, hardware clears and interrupt status
  always_comb begin
    next_flag_ctl   = flag_ctl;
    next_upper_lo   = upper_lo;
    next_upper_hi   = upper_hi;
    next_lower_lo   = lower_lo;
    next_lower_hi   = lower_hi;
    next_dwell_lo   = dwell_lo;
    next_dwell_hi   = dwell_hi;
    next_sync_ctl   = sync_ctl;
    next_period0    = period0;
    next_period1    = period1;
    next_period2    = period2;
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    if (wr_i) begin
      unique case (addr_i)
        `TFM_OFS_FLAG_CTL:   next_flag_ctl = wdata_i & 8'h0D;
        `TFM_OFS_UPPER_LO:   next_upper_lo = wdata_i;
        `TFM_OFS_UPPER_HI:   next_upper_hi = wdata_i & `TFM_HI_MASK;
        `TFM_OFS_LOWER_LO:   next_lower_lo = wdata_i;
        `TFM_OFS_LOWER_HI:   next_lower_hi = wdata_i & `TFM_HI_MASK;
        `TFM_OFS_DWELL_LO:   next_dwell_lo = wdata_i;
        `TFM_OFS_DWELL_HI:   next_dwell_hi = wdata_i;
        `TFM_OFS_SYNC_CTL:   next_sync_ctl = wdata_i & 8'h03;
        `TFM_OFS_PERIOD0:    next_period0  = wdata_i;
        `TFM_OFS_PERIOD1:    next_period1  = wdata_i;
        `TFM_OFS_PERIOD2:    next_period2  = wdata_i;
        `TFM_OFS_IRQ_MASK:   next_irq_mask = wdata_i[2:0];
        `TFM_OFS_IRQ_STATUS: next_irq_status = irq_status & ~wdata_i[2:0]; // write one clears
        default: ;           // unmapped writes are dropped
      endcase
    end
    // the edge that was used wins over a same-cycle software write
    if (sync_hit && sync_ctl[`TFM_SYNC_NEXT]) begin
      next_sync_ctl[`TFM_SYNC_EN] = 1'b0;
    end
    // events set after the clear so a set is never lost
    if (next_pin && !threshold_flag_pin_o) begin
      next_irq_status[`TFM_IRQ_RISE] = 1'b1;
    end
    if (!next_pin && threshold_flag_pin_o) begin
      next_irq_status[`TFM_IRQ_FALL] = 1'b1;
    end
    if (sync_hit) begin
      next_irq_status[`TFM_IRQ_SYNC] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end

  // read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    next_rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        `TFM_OFS_FLAG_CTL:   next_rdata = flag_ctl;
        `TFM_OFS_UPPER_LO:   next_rdata = upper_lo;
        `TFM_OFS_UPPER_HI:   next_rdata = upper_hi;
        `TFM_OFS_LOWER_LO:   next_rdata = lower_lo;
        `TFM_OFS_LOWER_HI:   next_rdata = lower_hi;
        `TFM_OFS_DWELL_LO:   next_rdata = dwell_lo;
        `TFM_OFS_DWELL_HI:   next_rdata = dwell_hi;
        `TFM_OFS_SYNC_CTL:   next_rdata = sync_ctl;
        `TFM_OFS_PERIOD0:    next_rdata = period0;
        `TFM_OFS_PERIOD1:    next_rdata = period1;
        `TFM_OFS_PERIOD2:    next_rdata = period2;
        `TFM_OFS_IRQ_STATUS: next_rdata = {5'h00, irq_status};
        `TFM_OFS_IRQ_MASK:   next_rdata = {5'h00, irq_mask};
        `TFM_OFS_LIVE_STATE: next_rdata = {6'h00, flag_st == TFM_FLAG_HIGH, threshold_flag_pin_o};
        default:             next_rdata = 8'h00;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_ctl   <= `TFM_RST_BYTE;
      upper_lo   <= `TFM_RST_BYTE;
      upper_hi   <= `TFM_RST_BYTE;
      lower_lo   <= `TFM_RST_BYTE;
      lower_hi   <= `TFM_RST_BYTE;
      dwell_lo   <= `TFM_RST_BYTE;
      dwell_hi   <= `TFM_RST_BYTE;
      sync_ctl   <= `TFM_RST_BYTE;
      period0    <= `TFM_RST_PERIOD0;
      period1    <= `TFM_RST_PERIOD_HI;
      period2    <= `TFM_RST_PERIOD_HI;
      irq_status <= 3'h0;
      irq_mask   <= 3'h0;
      irq_o      <= 1'b0;
      rdata_o    <= 8'h00;
    end else if (ce_i) begin
      flag_ctl   <= next_flag_ctl;
      upper_lo   <= next_upper_lo;
      upper_hi   <= next_upper_hi;
      lower_lo   <= next_lower_lo;
      lower_hi   <= next_lower_hi;
      dwell_lo   <= next_dwell_lo;
      dwell_hi   <= next_dwell_hi;
      sync_ctl   <= next_sync_ctl;
      period0    <= next_period0;
      period1    <= next_period1;
      period2    <= next_period2;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      irq_o      <= next_irq;
      rdata_o    <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  force_value_a: assert property (
    ce_i && flag_ctl[`TFM_FLAG_FORCE] |=> threshold_flag_pin_o == $past(flag_ctl[`TFM_FLAG_FVAL]))
    else $error("forced pin does not follow force value");

  disabled_low_a: assert property (
    ce_i && !flag_ctl[`TFM_FLAG_EN] && !flag_ctl[`TFM_FLAG_FORCE] |=> !threshold_flag_pin_o)
    else $error("flag pin high while disabled");

  dwell_loaded_a: assert property (
    ce_i && !flag_ctl[`TFM_FLAG_EN] |=> dwell_cnt == $past(dwell_target))
    else $error("dwell counter not loaded while disabled");

  upper_rise_a: assert property (
    ce_i && flag_ctl[`TFM_FLAG_EN] && !flag_ctl[`TFM_FLAG_FORCE] && above_upper
    |=> threshold_flag_pin_o && flag_st == TFM_FLAG_HIGH)
    else $error("flag not raised above upper threshold");

  lower_hold_a: assert property (
    ce_i && flag_ctl[`TFM_FLAG_EN] && !flag_ctl[`TFM_FLAG_FORCE] && flag_st == TFM_FLAG_HIGH
    && !below_lower |=> threshold_flag_pin_o && dwell_cnt == $past(dwell_target))
    else $error("flag dropped or dwell not reloaded above lower threshold");

  dwell_step_a: assert property (
    ce_i && flag_ctl[`TFM_FLAG_EN] && flag_st == TFM_FLAG_HIGH && below_lower && !above_upper
    && dwell_cnt != 16'h0000 |=> dwell_cnt == $past(dwell_cnt) - 16'h0001 && flag_st == TFM_FLAG_HIGH)
    else $error("dwell counter did not step down");

  dwell_clear_a: assert property (
    ce_i && flag_ctl[`TFM_FLAG_EN] && !flag_ctl[`TFM_FLAG_FORCE] && flag_st == TFM_FLAG_HIGH
    && below_lower && !above_upper && dwell_cnt == 16'h0000 |=> !threshold_flag_pin_o)
    else $error("flag not cleared at end of dwell");

  sync_align_a: assert property (
    ce_i && sref_edge |=> (pcnt == 24'h000000) == ($past(sync_ctl[`TFM_SYNC_EN])
    || $past(pcnt) >= $past(period_val) - 24'h000001))
    else $error("period counter sync mismatch");

  next_clear_a: assert property (
    ce_i && sync_hit && sync_ctl[`TFM_SYNC_NEXT] |=> !sync_ctl[`TFM_SYNC_EN] && irq_status[`TFM_IRQ_SYNC])
    else $error("next-sync enable not cleared");

  period_wrap_a: assert property (
    ce_i && !sync_hit && pcnt >= period_val - 24'h000001 |=> pcnt == 24'h000000 && period_tick_o)
    else $error("period counter did not wrap");

  irq_level_a: assert property (
    irq_o == |(irq_status & irq_mask))
    else $error("interrupt level mismatch");

  flag_cycle_c: cover property (
    threshold_flag_pin_o ##1 !threshold_flag_pin_o && flag_ctl[`TFM_FLAG_EN]);
  next_sync_c: cover property (
    sync_hit && sync_ctl[`TFM_SYNC_NEXT]);
  cont_sync_c: cover property (
    sync_hit && !sync_ctl[`TFM_SYNC_NEXT]);
  forced_c: cover property (
    flag_ctl[`TFM_FLAG_FORCE] && threshold_flag_pin_o);

endmodule
`default_nettype wire

// ==== tfm_sref_src.sv ====
// Purpose: timing reference source model facing the threshold flag block
// Assumes: pulse spacing is a whole multiple of the monitor period
// Notes:   pin idles low between pulses; edges sit off the clock edge
`timescale 1ns/1ps
`default_nettype none
module tfm_sref_src #(
  parameter int MULT = 2  // monitor periods between pulses
) (
  input  wire logic        mclk_i,   // board clock, used only for spacing
  input  wire logic        en_i,     // reference input enabled by controller
  input  wire logic [23:0] period_i, // programmed monitor period
  output logic             sysref_o  // timing reference pin
);
  // one pulse every MULT periods, four cycles wide, only while enabled
  initial begin
    sysref_o = 1'b0;
    forever begin
      @(posedge mclk_i);
      if (en_i) begin
        // spacing of MULT whole periods keeps continuous resync harmless
        repeat (MULT * int'(period_i) - 5) @(posedge mclk_i);
        #7 sysref_o = 1'b1;
        repeat (4) @(posedge mclk_i);
        #7 sysref_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tfm_top_tb_top.sv ====
// Purpose: self-checking bench for the threshold flag and monitor sync block
// Assumes: 40 MHz clock, reference pulses from tfm_sref_src
// Notes:   each scenario is one task that drives and judges
`timescale 1ns/1ps
`default_nettype none
`include "tfm_regs.svh"
module tfm_top_tb_top;
  logic        mclk_i;      // bench clock
  logic        rst_n_i;     // async reset, active low
  logic        ce_i;        // clock enable
  logic [9:0]  addr_i;      // register offset
  logic [7:0]  wdata_i;     // write data
  logic        wr_i;        // write strobe
  logic        rd_i;        // read strobe
  logic [7:0]  rdata_o;     // read data
  logic [12:0] fine_mag_i;  // magnitude stimulus
  logic        sysref_i;    // reference pin from the model
  logic        flag_o;      // flag pin
  logic        tick_o;      // period boundary
  logic        irq_o;       // interrupt
  logic        sref_en;     // reference input enabled
  int          checks;      // comparisons made
  int          miscompares; // mismatches seen
  logic [9:0]  ofs [10] = '{`TFM_OFS_FLAG_CTL, `TFM_OFS_UPPER_LO, `TFM_OFS_UPPER_HI, `TFM_OFS_LOWER_LO,
                            `TFM_OFS_LOWER_HI, `TFM_OFS_DWELL_LO, `TFM_OFS_DWELL_HI, `TFM_OFS_SYNC_CTL,
                            `TFM_OFS_PERIOD1, `TFM_OFS_PERIOD2};

  tfm_top tfm_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fine_mag_i(fine_mag_i), .sysref_i(sysref_i),
    .threshold_flag_pin_o(flag_o), .period_tick_o(tick_o), .irq_o(irq_o));
  tfm_sref_src #(.MULT(2)) tfm_sref_src_inst (.mclk_i(mclk_i), .en_i(sref_en), .period_i(24'd16),
    .sysref_o(sysref_i));

  // free-running 25 ns clock
  always #12.5 mclk_i = ~mclk_i;

  // verdict and end of run, also reached from any timeout
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string msg);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 chk(rdata_o, exp, msg);
  endtask

  task automatic setmag(input logic [12:0] v);
    @(posedge mclk_i);
    fine_mag_i <= v;
  endtask

  // bounded wait for the interrupt line
  task automatic wait_irq(input int n);
    for (int i = 0; i < n && irq_o !== 1'b1; i++) cyc(1);
    if (irq_o !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t interrupt never came", $time);
      end_sim();
    end
  endtask

  // cycles from now to the next boundary pulse
  task automatic tick_after(input int exp);
    int n;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (tick_o !== 1'b1 && n < 300);
    if (n >= 300) begin
      miscompares++;
      $display("[FAIL] %0t boundary pulse never came", $time);
      end_sim();
    end
    chk(n[7:0], exp[7:0], "tick gap");
  endtask

  // cycles between two boundary pulses; the #1 keeps the first look off the edge
  task automatic tick_gap(input int exp);
    int n;
    n = 0;
    #1;
    while (tick_o !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) begin
      miscompares++;
      $display("[FAIL] %0t first boundary pulse never came", $time);
      end_sim();
    end
    tick_after(exp);
  endtask

  // reset values, reserved-bit masking, unmapped read, frozen write
  task automatic t_regs();
    foreach (ofs[i]) rd(ofs[i], `TFM_RST_BYTE, "reset value");
    rd(`TFM_OFS_PERIOD0, `TFM_RST_PERIOD0, "period reset");
    rd(10'h300, 8'h00, "unmapped");
    wr(`TFM_OFS_FLAG_CTL, 8'hFF);
    rd(`TFM_OFS_FLAG_CTL, 8'h0D, "flag ctl mask");
    wr(`TFM_OFS_UPPER_HI, 8'hFF);
    rd(`TFM_OFS_UPPER_HI, 8'h1F, "upper hi mask");
    wr(`TFM_OFS_LOWER_HI, 8'hFF);
    rd(`TFM_OFS_LOWER_HI, 8'h1F, "lower hi mask");
    wr(`TFM_OFS_FLAG_CTL, 8'h00);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(`TFM_OFS_DWELL_LO, 8'h55);
    ce_i <= 1'b1;
    rd(`TFM_OFS_DWELL_LO, 8'h00, "frozen write");
  endtask

  // thresholds 0x1234 / 0x0105, dwell 0x0103, then force
  task automatic t_flag();
    wr(`TFM_OFS_UPPER_LO, 8'h34);
    wr(`TFM_OFS_UPPER_HI, 8'h12);
    wr(`TFM_OFS_LOWER_LO, 8'h05);
    wr(`TFM_OFS_LOWER_HI, 8'h01);
    wr(`TFM_OFS_DWELL_LO, 8'h03);
    wr(`TFM_OFS_DWELL_HI, 8'h01);
    setmag(13'h1FFF);
    cyc(3);
    chk({7'h0, flag_o}, 8'h00, "disabled pin");
    setmag(13'h1234);
    wr(`TFM_OFS_FLAG_CTL, 8'h01);
    cyc(3);
    chk({7'h0, flag_o}, 8'h00, "equal upper");
    setmag(13'h1235);
    cyc(1);
    chk({7'h0, flag_o}, 8'h01, "above upper");
    rd(`TFM_OFS_LIVE_STATE, 8'h03, "live high");
    setmag(13'h0105);
    cyc(300);
    chk({7'h0, flag_o}, 8'h01, "equal lower holds");
    setmag(13'h0104);
    cyc(259);
    chk({7'h0, flag_o}, 8'h01, "dwell not done");
    cyc(1);
    chk({7'h0, flag_o}, 8'h00, "dwell done");
    setmag(13'h1FFF);
    wr(`TFM_OFS_FLAG_CTL, 8'h0C);
    cyc(2);
    chk({7'h0, flag_o}, 8'h01, "forced high, disabled");
    rd(`TFM_OFS_LIVE_STATE, 8'h01, "live forced");
    wr(`TFM_OFS_FLAG_CTL, 8'h09);
    cyc(2);
    chk({7'h0, flag_o}, 8'h00, "forced low over compare");
    wr(`TFM_OFS_FLAG_CTL, 8'h01);
    cyc(2);
    chk({7'h0, flag_o}, 8'h01, "force released");
  endtask

  // sticky status, mask and write-one clear on the flag fall
  task automatic t_irq();
    wr(`TFM_OFS_IRQ_STATUS, 8'h07);
    wr(`TFM_OFS_IRQ_MASK, 8'h01);
    setmag(13'h0000);
    cyc(270);
    chk({7'h0, irq_o}, 8'h00, "fall masked");
    rd(`TFM_OFS_IRQ_STATUS, 8'h02, "fall status");
    wr(`TFM_OFS_IRQ_MASK, 8'h03);
    cyc(2);
    chk({7'h0, irq_o}, 8'h01, "fall unmasked");
    wr(`TFM_OFS_IRQ_STATUS, 8'h02);
    cyc(2);
    chk({7'h0, irq_o}, 8'h00, "fall cleared");
  endtask

  // period boundaries, then sync off, continuous and next mode
  task automatic t_sync();
    tick_gap(128);
    wr(`TFM_OFS_PERIOD0, 8'h10);
    tick_gap(16);
    wr(`TFM_OFS_IRQ_MASK, 8'h04);
    sref_en <= 1'b1;
    cyc(80);
    rd(`TFM_OFS_IRQ_STATUS, 8'h00, "sync off");
    wr(`TFM_OFS_SYNC_CTL, 8'h01);
    wait_irq(100);
    tick_after(16);
    rd(`TFM_OFS_SYNC_CTL, 8'h01, "continuous keeps enable");
    wr(`TFM_OFS_IRQ_STATUS, 8'h04);
    cyc(2);
    wait_irq(100);
    wr(`TFM_OFS_IRQ_STATUS, 8'h04);
    wr(`TFM_OFS_SYNC_CTL, 8'h03);
    cyc(2);
    wait_irq(100);
    rd(`TFM_OFS_SYNC_CTL, 8'h02, "next clears enable");
    wr(`TFM_OFS_IRQ_STATUS, 8'h04);
    cyc(80);
    chk({7'h0, irq_o}, 8'h00, "later edges ignored");
  endtask

  // reset for eight cycles, then the scenarios
  initial begin
    mclk_i = 1'b0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    addr_i = 10'h000;
    wdata_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    fine_mag_i = 13'h0000;
    sref_en = 1'b0;
    checks = 0;
    miscompares = 0;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_flag();
    t_irq();
    t_sync();
    end_sim();
  end
endmodule
`default_nettype wire
